// ==== src/flash_lock_dev.sv ====
// flash side: lock bit array, global and single lock commands, soft reset
// assumes: link from spi_lock_if.dev in mode 0; status logic outside
// supplies the latch and range bits and acts on soft_reset_pulse
`timescale 1ns/100ps
`default_nettype none
`include "lock_cfg.svh"
module flash_lock_dev
  import lock_pkg::*;
#(
  parameter int IDX_W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  spi_lock_if.dev           link,
  input  wire logic         lock_scheme_select,
  input  wire logic         protect_complement,
  input  wire logic         sector_granularity,
  input  wire logic         top_bottom_select,
  input  wire logic [2:0]   protect_range_bits,
  input  wire logic         write_enable_latch,
  input  wire logic [23:0]  check_addr,
  output logic              check_protected,
  output logic              soft_reset_pulse,
  output logic              reset_busy,
  output logic              lock_cmd_done
);
  localparam int NUM_LOCKS = 1 << IDX_W;
  localparam logic [11:0] RST_CNT = 12'(`RST_CYCLES);

  logic                 fresh_reg;
  logic [5:0]           cnt_reg;
  logic [31:0]          sh_reg;
  logic                 so_reg;
  logic                 oe_reg;
  logic [NUM_LOCKS-1:0] lock_reg;
  logic                 cs_s1_reg;
  logic                 cs_s2_reg;
  logic                 cs_s3_reg;
  logic                 armed_reg;
  logic [11:0]          rst_cnt_reg;
  logic [7:0]           op;
  logic [IDX_W-1:0]     idx;
  logic                 frame_end;
  logic                 len_ok;
  logic                 valid_cmd;
  logic                 fire;
  logic                 wel_ok;
  logic [12:0]          unit;
  logic [12:0]          span;
  logic [12:0]          total;
  logic                 range_hit;

  // a bare command byte ends in the low bits; address frames leave it on top
  assign op  = (cnt_reg < `LEN_ADDR) ? sh_reg[7:0] : sh_reg[31:24];
  assign idx = sh_reg[23 -: IDX_W];

  // link side: cs_n high marks the next rising edge as the first bit
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // [R04] count bits of frame
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 6'h00;
    end else if (fresh_reg) begin
      cnt_reg <= 6'h01;
    end else if (cnt_reg != `LEN_MAX) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // [R04] shift opcode and address
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      sh_reg <= 32'h0000_0000;
    end else if (fresh_reg) begin
      sh_reg <= {31'h0000_0000, link.serial_in_line};
    end else if (cnt_reg < `LEN_ADDR) begin
      sh_reg <= {sh_reg[30:0], link.serial_in_line};
    end
  end

  // [R05] lock byte on falling edges
  // lock_reg only changes at frame end, so it is stable while read here
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      so_reg <= 1'b0;
    end else if (op == `OPC_READ_LOCK && cnt_reg == `LEN_READ - 6'd1) begin
      so_reg <= lock_reg[idx];
    end else begin
      so_reg <= 1'b0;
    end
  end

  // output is released as soon as the frame ends
  always_ff @(negedge link.sclk or posedge rst or posedge link.cs_n) begin
    if (rst || link.cs_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (op == `OPC_READ_LOCK) && (cnt_reg >= `LEN_ADDR);
    end
  end

  assign link.so_drv = so_reg;
  assign link.so_oe  = oe_reg;

  // core side: the frame end is seen through a two-stage synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end else begin
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  // cnt_reg and sh_reg are quiet while cs_n is high, so they are read
  // here without a further stage; the host must keep cs_n high a few cycles
  assign frame_end = cs_s2_reg & ~cs_s3_reg;

  // [R17] exact length for lock and reset commands, at least 8 bits for others
  always_comb begin
    case (op)
      `OPC_GLOBAL_LOCK,
      `OPC_GLOBAL_UNLK,
      `OPC_RESET_ENABLE,
      `OPC_RESET_DEVICE: len_ok = (cnt_reg == `LEN_CMD);
      `OPC_BLOCK_LOCK,
      `OPC_BLOCK_UNLK:   len_ok = (cnt_reg == `LEN_ADDR);
      default:           len_ok = (cnt_reg >= `LEN_CMD);
    endcase
  end

  // [R11] ignore while resetting
  assign valid_cmd = frame_end && len_ok && !reset_busy;
  // [R09] reset needs armed state
  assign fire      = valid_cmd && (op == `OPC_RESET_DEVICE) && armed_reg;
  // [R08] latch gates writes
  assign wel_ok    = valid_cmd && write_enable_latch;

  // [R10] any other command disarms
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (fire) begin
      armed_reg <= 1'b0;
    end else if (valid_cmd) begin
      armed_reg <= (op == `OPC_RESET_ENABLE);
    end
  end

  // [R11] recovery period timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_reg <= 12'h000;
    end else if (fire) begin
      rst_cnt_reg <= RST_CNT;
    end else if (rst_cnt_reg != 12'h000) begin
      rst_cnt_reg <= rst_cnt_reg - 12'h001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_busy <= 1'b0;
    end else begin
      reset_busy <= fire || (rst_cnt_reg > 12'h001);
    end
  end

  // [R12] pulse clears volatile state
  // outside logic aborts work, clears latch, suspend, P and W bits on it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= fire;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_cmd_done <= 1'b0;
    end else begin
      lock_cmd_done <= wel_ok && (op == `OPC_GLOBAL_LOCK
                                  || op == `OPC_GLOBAL_UNLK
                                  || op == `OPC_BLOCK_LOCK
                                  || op == `OPC_BLOCK_UNLK);
    end
  end

  // one bit per block, all updated only at a frame end
  for (genvar i = 0; i < NUM_LOCKS; i++) begin : g_lock
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        // [R03] locked after power-up
        lock_reg[i] <= `LOCK_RESET_VAL;
      end else if (fire) begin
        // [R03] locked after soft reset
        lock_reg[i] <= `LOCK_RESET_VAL;
      end else if (wel_ok) begin
        case (op)
          // [R06] global lock sets all
          `OPC_GLOBAL_LOCK: lock_reg[i] <= 1'b1;
          // [R07] global unlock clears all
          `OPC_GLOBAL_UNLK: lock_reg[i] <= 1'b0;
          // [R15] single block lock
          `OPC_BLOCK_LOCK: begin
            if (idx == IDX_W'(i)) begin
              lock_reg[i] <= 1'b1;
            end
          end
          // [R16] single block unlock
          `OPC_BLOCK_UNLK: begin
            if (idx == IDX_W'(i)) begin
              lock_reg[i] <= 1'b0;
            end
          end
          default: lock_reg[i] <= lock_reg[i];
        endcase
      end
    end
  end

  // range scheme: 2^(bp-1) units at the top or bottom, in blocks or
  // in 4 KB sectors; complement turns the protected region round
  always_comb begin
    if (sector_granularity) begin
      unit  = {1'b0, check_addr[23:12]};
      total = 13'h1000;
    end else begin
      unit  = {5'h00, check_addr[23:16]};
      total = 13'h0100;
    end
    if (protect_range_bits == 3'h0) begin
      span = 13'h0000;
    end else begin
      span = 13'h0001 << (protect_range_bits - 3'h1);
    end
    if (top_bottom_select) begin
      range_hit = unit < span;
    end else begin
      range_hit = unit >= (total - span);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      check_protected <= 1'b1;
    end else if (lock_scheme_select) begin
      // [R01] per-block locks decide
      check_protected <= lock_reg[check_addr[23 -: IDX_W]];
    end else begin
      // [R02] range bits decide
      check_protected <= range_hit ^ protect_complement;
    end
  end

endmodule // flash_lock_dev
`default_nettype wire

// ==== src/lock_cfg.svh ====
// constants for the block lock and soft reset command logic of a serial flash
// assumes: included by bare name; core clock runs at CORE_MHZ
// Operation
// [R01] Lock bits protect only when scheme select set
// [R02] Scheme select clear: range bits decide protection
// [R03] Lock bits volatile, all ones after reset
// [R04] Host queries lock: 3Dh plus 24-bit address
// [R05] Device shifts lock byte out, LSB one=locked
// [R06] Command 7Eh alone sets every lock bit
// [R07] Command 98h alone clears every lock bit
// [R08] Global commands need write enable latch set
// [R09] Reset needs 66h then 99h, consecutive
// [R10] Any other command after 66h disarms reset
// [R11] Reset takes 30us, no commands meanwhile
// [R12] Reset aborts work, clears volatile settings
// [R13] Host checks busy/suspend idle before reset
// [R14] Host waits 5 ms before write commands
// [R15] 36h plus address locks one block, needs latch
// [R16] 39h plus address unlocks one block, needs latch
// [R17] Short frame discards command, state unchanged
`ifndef LOCK_CFG_SVH
`define LOCK_CFG_SVH
`define OPC_READ_LOCK    8'h3d
`define OPC_GLOBAL_LOCK  8'h7e
`define OPC_GLOBAL_UNLK  8'h98
`define OPC_RESET_ENABLE 8'h66
`define OPC_RESET_DEVICE 8'h99
`define OPC_BLOCK_LOCK   8'h36
`define OPC_BLOCK_UNLK   8'h39
`define LEN_CMD          6'd8
`define LEN_ADDR         6'd32
`define LEN_READ         6'd40
`define LEN_MAX          6'h3f
`define LOCK_RESET_VAL   1'b1
`define CORE_MHZ         100
`define RST_TIME_US      30
`define RST_CYCLES       (`RST_TIME_US * `CORE_MHZ)
`define PUW_TIME_MS      5
`define PUW_CYCLES       (`PUW_TIME_MS * 1000 * `CORE_MHZ)
`define GAP_CYCLES       8
`define SCLK_HALF        4
`endif

// ==== src/lock_pkg.sv ====
// types shared by both ends of the lock command link
// assumes: nothing beyond the compile order
package lock_pkg;
  typedef enum logic [2:0] {
    OP_READ_LOCK, OP_BLOCK_LOCK, OP_BLOCK_UNLK, OP_GLOBAL_LOCK,
    OP_GLOBAL_UNLK, OP_RESET_ENABLE, OP_RESET_DEVICE
  } host_op_e;
  typedef enum {ST_POWERUP, ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP,
                ST_RST_WAIT} host_state_e;
endpackage

// ==== src/spi_lock_if.sv ====
// serial link between the host controller and the flash lock logic
// assumes: host makes sclk, cs_n and serial_in_line; so line idles high
`timescale 1ns/100ps
`default_nettype none
interface spi_lock_if;
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic so_drv;
  logic so_oe;
  logic so_line;
  // weak pull-up when the device lets go of the output
  assign so_line = so_oe ? so_drv : 1'b1;
  modport dev  (input sclk, input cs_n, input serial_in_line,
                output so_drv, output so_oe);
  modport host (output sclk, output cs_n, output serial_in_line,
                input so_line);
endinterface // spi_lock_if
`default_nettype wire

// ==== src/spi_lock_host.sv ====
// host side: issues lock, unlock, query and reset frames on the link
// assumes: sclk made here by dividing core_clk; one request at a time
`timescale 1ns/100ps
`default_nettype none
`include "lock_cfg.svh"
module spi_lock_host
  import lock_pkg::*;
#(
  parameter int PUW_CYCLES = `PUW_CYCLES
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  spi_lock_if.host          link,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire host_op_e     req_op,
  input  wire logic [23:0]  req_addr,
  input  wire logic         flash_idle,
  output logic              done_pulse,
  output logic [7:0]        read_byte
);
  localparam logic [2:0]  HALF_LAST = 3'(`SCLK_HALF - 1);
  localparam logic [11:0] RST_WAIT  = 12'(`RST_CYCLES);

  host_state_e  state_reg;
  logic [22:0]  pw_cnt_reg;
  logic [11:0]  wait_reg;
  logic [2:0]   half_reg;
  logic [5:0]   fall_reg;
  logic [5:0]   nbits_reg;
  logic [31:0]  tx_reg;
  logic         sclk_reg;
  logic         cs_n_reg;
  logic         din_reg;
  logic         so_s1_reg;
  logic         so_s2_reg;
  logic         rst_frame_reg;
  logic         is_write;
  logic [7:0]   opc;
  logic [5:0]   nb;
  logic         half_end;
  logic         puw_done;

  assign puw_done            = (pw_cnt_reg == 23'(PUW_CYCLES));
  assign link.sclk           = sclk_reg;
  assign link.cs_n           = cs_n_reg;
  assign link.serial_in_line = din_reg;
  assign half_end            = (half_reg == HALF_LAST);

  always_comb begin
    case (req_op)
      OP_READ_LOCK:    begin opc = `OPC_READ_LOCK;    nb = `LEN_READ; end
      OP_BLOCK_LOCK:   begin opc = `OPC_BLOCK_LOCK;   nb = `LEN_ADDR; end
      OP_BLOCK_UNLK:   begin opc = `OPC_BLOCK_UNLK;   nb = `LEN_ADDR; end
      OP_GLOBAL_LOCK:  begin opc = `OPC_GLOBAL_LOCK;  nb = `LEN_CMD;  end
      OP_GLOBAL_UNLK:  begin opc = `OPC_GLOBAL_UNLK;  nb = `LEN_CMD;  end
      OP_RESET_ENABLE: begin opc = `OPC_RESET_ENABLE; nb = `LEN_CMD;  end
      default:         begin opc = `OPC_RESET_DEVICE; nb = `LEN_CMD;  end
    endcase
  end

  assign is_write = (req_op != OP_READ_LOCK);

  // [R14] writes wait out power-up
  // [R13] reset only when flash idle
  always_comb begin
    case (state_reg)
      // the gate holds in idle too, since a read may end before power-up does
      ST_POWERUP,
      ST_IDLE: req_ready = (!is_write || puw_done)
                           && ((req_op != OP_RESET_DEVICE) || flash_idle);
      default: req_ready = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      so_s1_reg <= 1'b1;
      so_s2_reg <= 1'b1;
    end else begin
      so_s1_reg <= link.so_line;
      so_s2_reg <= so_s1_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pw_cnt_reg <= 23'h000000;
    end else if (pw_cnt_reg != 23'(PUW_CYCLES)) begin
      pw_cnt_reg <= pw_cnt_reg + 23'h000001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_POWERUP;
      half_reg      <= 3'h0;
      fall_reg      <= 6'h00;
      nbits_reg     <= 6'h00;
      tx_reg        <= 32'h0000_0000;
      sclk_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      din_reg       <= 1'b0;
      wait_reg      <= 12'h000;
      rst_frame_reg <= 1'b0;
      done_pulse    <= 1'b0;
      read_byte     <= 8'h00;
    end else begin
      done_pulse <= 1'b0;
      case (state_reg)
        ST_POWERUP, ST_IDLE: begin
          if (req_valid && req_ready) begin
            // [R04] opcode then address
            tx_reg        <= {opc, req_addr};
            din_reg       <= opc[7];
            nbits_reg     <= nb;
            // [R09] reset command starts wait
            rst_frame_reg <= (req_op == OP_RESET_DEVICE);
            cs_n_reg      <= 1'b0;
            half_reg      <= 3'h0;
            fall_reg      <= 6'h00;
            state_reg     <= ST_SHIFT;
          end else if (puw_done) begin
            state_reg     <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          half_reg <= half_end ? 3'h0 : half_reg + 3'h1;
          if (half_end && !sclk_reg) begin
            sclk_reg <= 1'b1;
          end else if (half_end) begin
            sclk_reg <= 1'b0;
            fall_reg <= fall_reg + 6'h01;
            tx_reg   <= {tx_reg[30:0], 1'b0};
            din_reg  <= tx_reg[30];
            // synced line still shows the bit of the previous falling edge
            if (fall_reg >= `LEN_ADDR) begin
              read_byte <= {read_byte[6:0], so_s2_reg};
            end
            if (fall_reg + 6'h01 == nbits_reg) begin
              state_reg <= ST_TAIL;
            end
          end
        end
        ST_TAIL: begin
          half_reg <= half_end ? 3'h0 : half_reg + 3'h1;
          if (half_end) begin
            // [R06] frame ends after last byte
            // [R07] frame ends after last byte
            cs_n_reg  <= 1'b1;
            wait_reg  <= 12'(`GAP_CYCLES);
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (wait_reg != 12'h000) begin
            wait_reg <= wait_reg - 12'h001;
          end else if (rst_frame_reg) begin
            // [R11] hold off during recovery
            wait_reg  <= RST_WAIT;
            state_reg <= ST_RST_WAIT;
          end else begin
            done_pulse <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_RST_WAIT: begin
          if (wait_reg != 12'h000) begin
            wait_reg <= wait_reg - 12'h001;
          end else begin
            done_pulse <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // spi_lock_host
`default_nettype wire

// ==== test/lock_link_asserts.sv ====
// concurrent checks on the lock command link and the flash end's status pulses
// assumes: instantiated beside the link in the bench; core_clk samples all inputs
`timescale 1ns/100ps
`default_nettype none
module lock_link_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic so_drv,
  input wire logic so_oe,
  input wire logic lock_cmd_done,
  input wire logic soft_reset_pulse,
  input wire logic reset_busy
);
  logic [5:0]  rise_cnt_reg;
  logic [5:0]  last_len_reg;
  logic [11:0] busy_len_reg;
  logic        sclk_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b0;
      rise_cnt_reg <= 6'h0;
    end else begin
      sclk_reg <= sclk;
      if (cs_n) begin
        rise_cnt_reg <= 6'h0;
      end else if (sclk && !sclk_reg) begin
        rise_cnt_reg <= rise_cnt_reg + 6'h1;
      end
    end
  end
  // bit count of the frame that closed last, held until the next one closes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_len_reg <= 6'h0;
    end else if (cs_n && rise_cnt_reg != 6'h0) begin
      last_len_reg <= rise_cnt_reg;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_len_reg <= 12'h0;
    end else begin
      busy_len_reg <= reset_busy ? busy_len_reg + 12'h1 : 12'h0;
    end
  end
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  chk_din_steady: assert property ($rose(sclk) |-> $stable(serial_in_line))
    else $error("input line moved at rising clock");
  chk_out_window: assert property (so_oe && !cs_n |-> rise_cnt_reg >= 6'd32)
    else $error("output driven before address complete");
  chk_lead_zeros: assert property (so_oe && !cs_n && rise_cnt_reg < 6'd39 |-> !so_drv)
    else $error("upper lock byte bits not zero");
  chk_out_on_fall: assert property (so_oe && !cs_n && $changed(so_drv) |-> $fell(sclk))
    else $error("output changed off falling clock");
  chk_out_release: assert property ($rose(cs_n) |-> ##[0:3] !so_oe)
    else $error("output still driven after deselect");
  chk_cmd_len: assert property (lock_cmd_done |->
    (last_len_reg == 6'd8 || last_len_reg == 6'd32) && $past(cs_n, 3))
    else $error("lock command done after bad frame");
  chk_reset_len: assert property (soft_reset_pulse |->
    (last_len_reg == 6'd8) ##1 !soft_reset_pulse)
    else $error("reset pulse after bad frame or too long");
  chk_busy_follows: assert property (soft_reset_pulse |-> ##[0:1] reset_busy)
    else $error("reset busy not raised");
  chk_busy_length: assert property ($fell(reset_busy) |-> busy_len_reg == 12'd3000)
    else $error("reset busy length wrong");
  chk_quiet_busy: assert property (reset_busy |-> cs_n && !lock_cmd_done)
    else $error("activity during reset busy");
endmodule // lock_link_asserts
`default_nettype wire

// ==== test/block_lock_and_soft_reset_cmds_tb.sv ====
// bench: host and flash ends joined over one link, plus a second flash end
// fed by a rogue frame generator that breaks framing on purpose
// assumes: design sources compiled first; core clock 100 MHz
`timescale 1ns/100ps
`default_nettype none
module block_lock_and_soft_reset_cmds_tb;
  import lock_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  host_op_e    req_op = OP_READ_LOCK;
  logic [23:0] req_addr = 24'h0;
  logic        flash_idle = 1'b1;
  logic        lock_scheme_select = 1'b1;
  logic        protect_complement = 1'b0;
  logic        sector_granularity = 1'b0;
  logic        top_bottom_select = 1'b0;
  logic [2:0]  protect_range_bits = 3'h0;
  logic        write_enable_latch = 1'b0;
  logic [23:0] check_addr = 24'h0;
  logic [7:0]  read_byte;
  logic        req_ready, done_pulse, check_protected, soft_reset_pulse;
  logic        reset_busy, lock_cmd_done, cp2, srp2;
  logic        exp_lock [256];
  logic [23:0] a;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n_lock = 0;
  int          n_rst = 0;
  int          n_rst2 = 0;
  always #5 core_clk = ~core_clk;
  spi_lock_if spi_lock_if_i ();
  spi_lock_if spi_lock_if_i2 ();
  spi_lock_host #(.PUW_CYCLES(600)) spi_lock_host_i (.core_clk, .rst,
    .link(spi_lock_if_i), .req_valid, .req_ready, .req_op, .req_addr, .flash_idle,
    .done_pulse, .read_byte);
  flash_lock_dev flash_lock_dev_i (.core_clk, .rst, .link(spi_lock_if_i),
    .lock_scheme_select, .protect_complement, .sector_granularity, .top_bottom_select,
    .protect_range_bits, .write_enable_latch, .check_addr, .check_protected,
    .soft_reset_pulse, .reset_busy, .lock_cmd_done);
  flash_lock_dev flash_lock_dev_i2 (.core_clk, .rst, .link(spi_lock_if_i2),
    .lock_scheme_select, .protect_complement, .sector_granularity, .top_bottom_select,
    .protect_range_bits, .write_enable_latch, .check_addr, .check_protected(cp2),
    .soft_reset_pulse(srp2), .reset_busy(), .lock_cmd_done());
  lock_link_asserts lock_link_asserts_i (.core_clk, .rst, .sclk(spi_lock_if_i.sclk),
    .cs_n(spi_lock_if_i.cs_n), .serial_in_line(spi_lock_if_i.serial_in_line),
    .so_drv(spi_lock_if_i.so_drv), .so_oe(spi_lock_if_i.so_oe), .lock_cmd_done,
    .soft_reset_pulse, .reset_busy);
  always @(posedge core_clk) begin
    if (lock_cmd_done === 1'b1) n_lock++;
    if (soft_reset_pulse === 1'b1) n_rst++;
    if (srp2 === 1'b1) n_rst2++;
  end
  function automatic logic prot_exp(input logic [23:0] ad);
    int sh;
    int idx;
    int n;
    sh = sector_granularity ? 12 : 16;
    n = (protect_range_bits == 3'h0) ? 0 : (1 << (protect_range_bits - 1));
    idx = int'(ad >> sh);
    if (!top_bottom_select) idx = (1 << (24 - sh)) - 1 - idx;
    return (idx < n) ^ protect_complement;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic set_all(input logic v);
    for (int i = 0; i < 256; i++) exp_lock[i] = v;
  endtask
  task automatic run_op(input host_op_e op, input logic [23:0] ad);
    int n;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = ad;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (done_pulse !== 1'b1 && n < 6000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 6000) miscompares++;
  endtask
  task automatic read_chk(input logic [23:0] ad);
    run_op(OP_READ_LOCK, ad);
    check(read_byte, {7'h0, exp_lock[ad[23:16]]});
  endtask
  // a request the host must hold off: ready stays low throughout
  task automatic refuse(input host_op_e op);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_op = op;
    repeat (20) begin
      @(negedge core_clk);
      check(req_ready, 1'b0);
    end
    req_valid = 1'b0;
  endtask
  // link clock made here at 48 ns; bit counts other than 8 break framing
  task automatic rogue(input logic [7:0] op, input int nbits);
    spi_lock_if_i2.cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_lock_if_i2.serial_in_line = (i < 8) ? op[7-i] : 1'b0;
      #24 spi_lock_if_i2.sclk = 1'b1;
      #24 spi_lock_if_i2.sclk = 1'b0;
    end
    #24 spi_lock_if_i2.cs_n = 1'b1;
    spi_lock_if_i2.serial_in_line = ~spi_lock_if_i2.serial_in_line;
    #200;
  endtask
  initial begin
    a = 24'($urandom(1));
    spi_lock_if_i2.sclk = 1'b0;
    spi_lock_if_i2.cs_n = 1'b1;
    spi_lock_if_i2.serial_in_line = 1'b0;
    set_all(1'b1);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    refuse(OP_GLOBAL_UNLK);
    read_chk(24'($urandom));
    // a read that ends inside the power-up wait must not open writes
    refuse(OP_GLOBAL_UNLK);
    for (int i = 0; i < 2; i++) read_chk(24'($urandom));
    run_op(OP_GLOBAL_UNLK, 24'h0);
    read_chk(24'($urandom));
    check(24'(n_lock), 24'h0);
    write_enable_latch = 1'b1;
    run_op(OP_GLOBAL_UNLK, 24'h0);
    set_all(1'b0);
    read_chk(24'hffffff);
    check(24'(n_lock), 24'h1);
    for (int i = 0; i < 10; i++) begin
      if (!i[0]) a = (i == 0) ? 24'hffffff : 24'($urandom);
      write_enable_latch = (i < 2) ? 1'b1 : 1'($urandom);
      run_op(i[0] ? OP_BLOCK_UNLK : OP_BLOCK_LOCK, a);
      if (write_enable_latch) exp_lock[a[23:16]] = !i[0];
      read_chk(a);
      read_chk(24'($urandom));
      check_addr = a;
      @(negedge core_clk);
      check(check_protected, exp_lock[a[23:16]]);
    end
    write_enable_latch = 1'b1;
    run_op(OP_GLOBAL_LOCK, 24'h0);
    set_all(1'b1);
    read_chk(24'($urandom));
    lock_scheme_select = 1'b0;
    for (int i = 0; i < 24; i++) begin
      {protect_complement, sector_granularity, top_bottom_select,
       protect_range_bits} = 6'($urandom);
      check_addr = 24'($urandom);
      if (i % 3 != 2) check_addr[23:18] = {6{i[0]}};
      @(negedge core_clk);
      check(check_protected, prot_exp(check_addr));
    end
    lock_scheme_select = 1'b1;
    run_op(OP_GLOBAL_UNLK, 24'h0);
    set_all(1'b0);
    run_op(OP_RESET_ENABLE, 24'h0);
    flash_idle = 1'b0;
    refuse(OP_RESET_DEVICE);
    flash_idle = 1'b1;
    run_op(OP_RESET_DEVICE, 24'h0);
    set_all(1'b1);
    check(24'(n_rst), 24'h1);
    read_chk(24'($urandom));
    run_op(OP_GLOBAL_UNLK, 24'h0);
    set_all(1'b0);
    run_op(OP_RESET_ENABLE, 24'h0);
    read_chk(24'($urandom));
    run_op(OP_RESET_DEVICE, 24'h0);
    check(24'(n_rst), 24'h1);
    read_chk(24'($urandom));
    rogue(8'h98, 7);
    check(cp2, 1'b1);
    rogue(8'h98, 9);
    check(cp2, 1'b1);
    rogue(8'h98, 8);
    check(cp2, 1'b0);
    rogue(8'h66, 8);
    rogue(8'h99, 5);
    check(24'(n_rst2), 24'h0);
    rogue(8'h99, 8);
    check(24'(n_rst2), 24'h1);
    rogue(8'h98, 8);
    check(cp2, 1'b1);
    repeat (3100) @(negedge core_clk);
    check(cp2, 1'b1);
    end_of_test();
  end
  // expected run is about 23k cycles; reaching the 60k-cycle limit means a hang
  initial begin
    #600us;
    miscompares++;
    end_of_test();
  end
endmodule // block_lock_and_soft_reset_cmds_tb
`default_nettype wire
